// ==== hdl/bil_pkg.sv ====
// bil_pkg: constants and types for the boot image loader
// assumes a single 10 MHz clock shared by every user of this package
package bil_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned BOOT_DELAY_MIN_NS = 15000;
  localparam int unsigned BOOT_DELAY_MAX_NS = 150000;
  localparam int unsigned BOOT_DELAY_CYC =
    (BOOT_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEC_BIT_OTP_BOOT = 5;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_SKIP_WORD = 32'h0d15ab1e;
  localparam logic [15:0] RAM_BASE = 16'h0000;
  localparam int unsigned RAM_ADDR_W = 16;

  typedef enum logic {BIL_SRC_FLASH, BIL_SRC_OTP} bil_src_t;

  typedef struct packed {
    logic we;
    logic [RAM_ADDR_W-1:0] addr;
    logic [31:0] data;
  } bil_ram_wr_t;

  typedef struct packed {
    logic run;
    logic halt;
    logic [RAM_ADDR_W-1:0] entry;
  } bil_exec_t;
endpackage : bil_pkg

// ==== hdl/bil_loader.sv ====
// bil_loader: reset sequencing, boot source pick, image load and crc check
// assumes image bytes arrive on a valid/ready stream from flash or otp
// Contract
// - core stays in reset while the external low-active reset pin is low
// - every general purpose pin has its pull-down enabled during reset
// - booting starts 15 to 150 us after reset release
// - security bit 5 set selects otp, else internal flash
// - read 32-bit word count, then four bytes per counted word
// - trailer word 0x0d15ab1e skips crc, else it is the expected crc
// - length and trailer words assembled least significant byte first
// - program written from lowest ram address and started there
// - crc covers length bytes and program bytes, not the trailer
// - reflected poly 0xedb88320, init all ones, residue inverted
`timescale 1ns/1ps
module bil_loader #(
  parameter int unsigned ADDR_W = bil_pkg::RAM_ADDR_W
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_rst_n,
  input wire logic [31:0] i_security,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  output logic o_byte_ready,
  output logic o_src_otp,
  output logic o_src_flash,
  output logic o_gpio_pd,
  output bil_pkg::bil_ram_wr_t o_ram,
  output bil_pkg::bil_exec_t o_exec
);
  typedef enum logic [2:0] {
    ST_HOLD, ST_DELAY, ST_LEN, ST_BODY, ST_TRAIL, ST_CHECK, ST_RUN, ST_HALT
  } bil_state_t;

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ (bil_pkg::CRC_POLY & {32{r[0] ^ b[i]}});
    end
    return r;
  endfunction : crc_byte

  bil_state_t state;
  bil_state_t next_state;
  logic [7:0] delay_cnt;
  logic [1:0] byte_cnt;
  logic [31:0] shift;
  logic [31:0] words_left;
  logic [31:0] crc;
  logic [ADDR_W-1:0] waddr;
  bil_pkg::bil_src_t src;

  wire in_reset = ~i_rst_n;
  wire take = i_byte_valid & o_byte_ready;
  wire word_done = take & (byte_cnt == 2'd3);
  wire [31:0] word_in = {i_byte, shift[31:8]};
  wire skip_crc = shift == bil_pkg::CRC_SKIP_WORD;
  wire crc_ok = ~crc == shift;
  wire delay_done = delay_cnt == 8'(bil_pkg::BOOT_DELAY_CYC - 1);

  assign o_byte_ready = ~in_reset & ((state == ST_LEN) | (state == ST_BODY)
                      | (state == ST_TRAIL));
  assign o_gpio_pd = in_reset | (state == ST_HOLD);
  assign o_src_otp = (src == bil_pkg::BIL_SRC_OTP) & o_byte_ready;
  assign o_src_flash = (src == bil_pkg::BIL_SRC_FLASH)
                     & o_byte_ready;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_HOLD: next_state = ST_DELAY;
      ST_DELAY: if (delay_done) next_state = ST_LEN;
      ST_LEN: if (word_done) begin
        next_state = (word_in == 32'h0) ? ST_TRAIL : ST_BODY;
      end
      ST_BODY: if (word_done && words_left == 32'h1) next_state = ST_TRAIL;
      ST_TRAIL: if (word_done) next_state = ST_CHECK;
      ST_CHECK: begin
        next_state = (skip_crc | crc_ok) ? ST_RUN : ST_HALT;
      end
      ST_RUN: next_state = ST_RUN;
      ST_HALT: next_state = ST_HALT;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || in_reset) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || state == ST_HOLD) begin
      delay_cnt <= 8'h00;
    end else if (state == ST_DELAY) begin
      delay_cnt <= delay_cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      src <= bil_pkg::BIL_SRC_FLASH;
    end else if (state == ST_HOLD) begin
      src <= i_security[bil_pkg::SEC_BIT_OTP_BOOT] ?
             bil_pkg::BIL_SRC_OTP : bil_pkg::BIL_SRC_FLASH;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || state == ST_HOLD) begin
      byte_cnt <= 2'd0;
      shift <= 32'h0;
    end else if (take) begin
      byte_cnt <= byte_cnt + 2'd1;
      shift <= word_in;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || state == ST_HOLD) begin
      crc <= bil_pkg::CRC_INIT;
    end else if (take && state != ST_TRAIL) begin
      crc <= crc_byte(crc, i_byte);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || state == ST_HOLD) begin
      words_left <= 32'h0;
    end else if (word_done && state == ST_LEN) begin
      words_left <= word_in;
    end else if (word_done && state == ST_BODY) begin
      words_left <= words_left - 32'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || in_reset || state == ST_HOLD) begin
      waddr <= ADDR_W'(bil_pkg::RAM_BASE);
      o_ram <= '0;
    end else begin
      o_ram.we <= word_done && state == ST_BODY;
      if (word_done && state == ST_BODY) begin
        o_ram.addr <= waddr;
        o_ram.data <= word_in;
        waddr <= waddr + ADDR_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || in_reset || state == ST_HOLD) begin
      o_exec <= '0;
    end else begin
      o_exec.run <= next_state == ST_RUN;
      o_exec.halt <= next_state == ST_HALT;
      o_exec.entry <= bil_pkg::RAM_BASE;
    end
  end

  // cycles since the reset pin let go, for the boot window check
  logic [10:0] boot_wait;
  always_ff @(posedge i_clk) begin
    if (i_reset || in_reset) begin
      boot_wait <= 11'h000;
    end else if (boot_wait != 11'h7ff) begin
      boot_wait <= boot_wait + 11'h001;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  a_hold_in_reset: assert property (in_reset |=> state == ST_HOLD)
    else $error("state left hold while reset pin low");
  a_pulldown_reset: assert property (in_reset |-> o_gpio_pd)
    else $error("pull-down off during reset");
  a_exec_reset: assert property (in_reset |=>
      !o_exec.run && !o_exec.halt)
    else $error("program running while reset pin low");
  a_boot_delay: assert property (
      (state == ST_HOLD && !in_reset) ##1 !in_reset [*8] |-> !o_byte_ready)
    else $error("boot began too early");
  a_boot_window: assert property ($rose(o_byte_ready) |->
      boot_wait >= 11'(bil_pkg::BOOT_DELAY_CYC) &&
      boot_wait <= 11'(bil_pkg::BOOT_DELAY_MAX_NS / bil_pkg::CLK_PERIOD_NS))
    else $error("boot start outside its window");
  a_src_select: assert property (o_byte_ready |->
      o_src_otp == i_security[bil_pkg::SEC_BIT_OTP_BOOT] ||
      $changed(i_security))
    else $error("wrong boot source");
  a_flash_src: assert property (o_byte_ready && !o_src_otp |->
      o_src_flash)
    else $error("flash not selected");
  a_len_lsb: assert property (
      state == ST_LEN && word_done |=> words_left == $past(word_in))
    else $error("length word misassembled");
  a_first_addr: assert property (state == ST_LEN && word_done |=>
      waddr == '0)
    else $error("load does not start at ram base");
  a_crc_freeze: assert property (state == ST_TRAIL && take |=>
      $stable(crc))
    else $error("trailer entered crc");
  a_bad_halt: assert property (
      state == ST_CHECK && !skip_crc && !crc_ok |=> ##1
      o_exec.halt && !o_exec.run)
    else $error("bad image not halted");
  a_good_run: assert property (
      state == ST_CHECK && (skip_crc || crc_ok) |=> ##1
      o_exec.run && o_exec.entry == '0)
    else $error("good image not started");
  a_crc_step: assert property (take && state == ST_LEN |=>
      crc == crc_byte($past(crc), $past(i_byte)))
    else $error("crc step wrong");

  c_run: cover property (o_exec.run);
  c_halt: cover property (o_exec.halt);
  c_skip: cover property (state == ST_CHECK && skip_crc);
  c_otp: cover property (o_src_otp && take);
  c_len_zero: cover property (state == ST_LEN && word_done && word_in == 32'h0);
endmodule : bil_loader

// ==== tb/bil_src_model.sv ====
// bil_src_model: byte source standing in for the boot flash or otp
// assumes the bench fills img before the loader leaves reset
`timescale 1ns/1ps
module bil_src_model (
  input wire logic i_clk,
  input wire logic i_ready,
  input wire logic i_slow,
  output logic o_valid,
  output logic [7:0] o_byte
);
  logic [7:0] img[$];
  logic gap = 1'b0;
  initial begin
    o_valid = 1'b0;
    o_byte = 8'h00;
  end
  always @(posedge i_clk) begin
    gap = 1'b0;
    if (o_valid === 1'b1 && i_ready === 1'b1 && img.size() > 0) begin
      void'(img.pop_front());
      gap = i_slow;
    end
    #1;
    o_valid = img.size() > 0 && !gap;
    // idle line inverts the byte it showed on every cycle, so the stale byte returns every other cycle
    o_byte = o_valid ? img[0] : ~o_byte;
  end
endmodule : bil_src_model

// ==== tb/bil_loader_tb.sv ====
// bil_loader_tb: boots table images through the loader and checks results
// assumes bil_pkg and bil_loader are compiled first
`timescale 1ns/1ps
module bil_loader_tb;
  typedef struct {int len; int mode; logic otp; logic slow;} bil_row_t;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_rst_n = 1'b0;
  logic slow = 1'b0;
  logic [31:0] i_security = 32'h0;
  logic byte_valid, byte_ready, src_otp, src_flash, gpio_pd;
  logic [7:0] byte_data;
  bil_pkg::bil_ram_wr_t ram;
  bil_pkg::bil_exec_t exec;
  logic [47:0] wr[$];
  int failures = 0;
  int checks_done = 0;
  int n;
  localparam int SUPPLY_SETTLE_CYC = 1000000 / bil_pkg::CLK_PERIOD_NS;
  // mode 0 good crc, 1 skip word, 2 bad crc
  bil_row_t rows[4] = '{'{0, 0, 1'b0, 1'b0}, '{1, 1, 1'b1, 1'b0},
    '{3, 2, 1'b0, 1'b1}, '{2, 0, 1'b1, 1'b1}};
  always #50 i_clk = ~i_clk;
  bil_loader u_bil_loader (.i_clk(i_clk), .i_reset(i_reset),
    .i_rst_n(i_rst_n), .i_security(i_security), .i_byte_valid(byte_valid),
    .i_byte(byte_data), .o_byte_ready(byte_ready), .o_src_otp(src_otp),
    .o_src_flash(src_flash), .o_gpio_pd(gpio_pd), .o_ram(ram),
    .o_exec(exec));
  bil_src_model u_bil_src_model (.i_clk(i_clk), .i_ready(byte_ready),
    .i_slow(slow), .o_valid(byte_valid), .o_byte(byte_data));
  always @(negedge i_clk) begin
    if (ram.we === 1'b1) wr.push_back({ram.addr, ram.data});
  end
  function automatic logic [31:0] body(int k);
    return 32'h5a3c0f00 + k * 32'h01030507;
  endfunction : body
  function automatic logic [31:0] crc_upd(logic [31:0] c, logic [7:0] b);
    c ^= {24'h0, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? (c >> 1) ^ bil_pkg::CRC_POLY : c >> 1;
    end
    return c;
  endfunction : crc_upd
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic cycles(int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask : cycles
  task automatic limit(int cap);
    if (n >= cap) begin
      failures++;
      $display("wrong value wait expected done seen timeout");
      conclude();
    end
  endtask : limit
  task automatic run_case(bil_row_t r);
    logic [31:0] crc, w;
    crc = bil_pkg::CRC_INIT;
    i_rst_n = 1'b0;
    i_security = {26'h0, r.otp, 5'h0};
    slow = r.slow;
    cycles(3);
    chk("pull_down", 1, gpio_pd);
    chk("exec_held", 0, exec);
    u_bil_src_model.img.delete();
    wr.delete();
    for (int k = -1; k <= r.len; k++) begin
      w = k < 0 ? r.len : body(k);
      if (k == r.len) begin
        w = r.mode == 1 ? bil_pkg::CRC_SKIP_WORD : ~crc ^ (r.mode == 2);
      end
      for (int j = 0; j < 4; j++) begin
        u_bil_src_model.img.push_back(w[8*j +: 8]);
        if (k < r.len) crc = crc_upd(crc, w[8*j +: 8]);
      end
    end
    i_rst_n = 1'b1;
    for (n = 0; byte_ready !== 1'b1 && n < 2000; n++) cycles(1);
    limit(2000);
    chk("boot_delay", 1, n >= 150 && n <= 1500);
    chk("source", {r.otp, ~r.otp}, {src_otp, src_flash});
    n = 0;
    while (exec.run !== 1'b1 && exec.halt !== 1'b1 && n < 3000) begin
      cycles(1);
      n++;
    end
    limit(3000);
    cycles(2);
    chk("exec", {r.mode != 2, r.mode == 2, 16'h0}, exec);
    chk("crc_verdict", r.mode == 2, exec.halt);
    chk("words", r.len, wr.size());
    foreach (wr[k]) chk("ram", {16'(k), body(k)}, wr[k]);
  endtask : run_case
  initial begin
    cycles(16);
    i_reset = 1'b0;
    // pin held low until the supply has been good for 1 ms
    cycles(SUPPLY_SETTLE_CYC);
    foreach (rows[i]) run_case(rows[i]);
    // abort a load in mid-body, then boot cleanly
    run_case(rows[1]);
    i_rst_n = 1'b0;
    cycles(2);
    u_bil_src_model.img = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22};
    i_rst_n = 1'b1;
    for (n = 0; u_bil_src_model.img.size() > 0 && n < 2000; n++) cycles(1);
    limit(2000);
    chk("abort_exec", 0, exec);
    run_case(rows[3]);
    i_reset = 1'b1;
    cycles(2);
    chk("house_reset", {1'b1, 18'h0}, {gpio_pd, exec});
    conclude();
  end
endmodule : bil_loader_tb
